// ==== design/imr_defs.svh ====
`ifndef IMR_DEFS_SVH
`define IMR_DEFS_SVH

// Register indices; byte address is four times the index
`define IMR_IDX_KEY      16'hffe4
`define IMR_IDX_CTIMER   16'hffe5
`define IMR_IDX_SW       16'hffe6
`define IMR_IDX_RF       16'hffe7
`define IMR_IDX_STATUS   16'hffd0
`define IMR_IDX_SMASK    16'hffd1

// Source positions in the request and status vectors
`define IMR_SRC_KEY1     0
`define IMR_SRC_CT32     1
`define IMR_SRC_CT3RD    2
`define IMR_SRC_CT2      3
`define IMR_SRC_CT1      4
`define IMR_SRC_SW10     5
`define IMR_SRC_SW1      6
`define IMR_SRC_LAP      7
`define IMR_SRC_RUN      8
`define IMR_SRC_RFM      9
`define IMR_SRC_RFB      10
`define IMR_NSRC         11

// Reset values
`define IMR_RST_MASK4    4'h0
`define IMR_RST_VEC      11'h000

`endif

// ==== design/imr_pkg.sv ====
package imr_pkg;

  // Bus handshake states, one-hot
  typedef enum logic [2:0] {
    IMR_IDLE = 3'b001,
    IMR_WAIT = 3'b010,
    IMR_RESP = 3'b100
  } imr_state_t;

endpackage

// ==== design/imr_top.sv ====
// Chosen here: the APB register port.
`include "imr_defs.svh"

module imr_top #(
  parameter int ADDR_W = 18
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [`IMR_NSRC-1:0] factor_flag,
  output logic      [`IMR_NSRC-1:0] irq_req,
  output logic                     irq
);

  // Register index match on the word address
  function automatic logic idx_hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    idx_hit = (a[ADDR_W-1:2] == idx[ADDR_W-3:0]);
  endfunction

  // Four-bit nibble into the low bits of a bus word
  function automatic logic [31:0] nib(input logic [3:0] v);
    nib = {28'h0000000, v};
  endfunction

  imr_pkg::imr_state_t st_q;
  imr_pkg::imr_state_t st_d;

  logic                 key1_q;
  logic [3:0]           ctimer_q;
  logic [3:0]           sw_q;
  logic [1:0]           rf_q;
  logic [`IMR_NSRC-1:0] stat_q;
  logic [`IMR_NSRC-1:0] smask_q;
  logic [`IMR_NSRC-1:0] req_q;
  logic [31:0]          prdata_q;
  logic                 pready_q;
  logic                 pslverr_q;
  logic                 irq_q;

  // Address decode
  wire hit_key    = idx_hit(paddr, `IMR_IDX_KEY);
  wire hit_ct     = idx_hit(paddr, `IMR_IDX_CTIMER);
  wire hit_sw     = idx_hit(paddr, `IMR_IDX_SW);
  wire hit_rf     = idx_hit(paddr, `IMR_IDX_RF);
  wire hit_stat   = idx_hit(paddr, `IMR_IDX_STATUS);
  wire hit_smask  = idx_hit(paddr, `IMR_IDX_SMASK);
  wire mapped     = hit_key | hit_ct | hit_sw | hit_rf | hit_stat | hit_smask;

  // Transfer completes on the access edge with pready high
  wire xfer_done  = psel & penable & pready_q;
  wire wr_en      = xfer_done & pwrite & mapped;
  wire start_acc  = (st_q == imr_pkg::IMR_WAIT);

  // Named enable bits, one per source
  wire key_group1_enable_bit        = key1_q;
  wire ctimer_1hz_enable_bit        = ctimer_q[3];
  wire ctimer_2hz_enable_bit        = ctimer_q[2];
  wire ctimer_third_enable_bit      = ctimer_q[1];
  wire ctimer_32hz_enable_bit       = ctimer_q[0];
  wire sw_run_key_enable_bit        = sw_q[3];
  wire sw_lap_key_enable_bit        = sw_q[2];
  wire sw_1hz_enable_bit            = sw_q[1];
  wire sw_10hz_enable_bit           = sw_q[0];
  wire rf_reference_done_enable_bit = rf_q[1];
  wire rf_sensor_done_enable_bit    = rf_q[0];

  // Mask vector in source order
  wire [`IMR_NSRC-1:0] mask_vec = {rf_reference_done_enable_bit, rf_sensor_done_enable_bit,
                                   sw_run_key_enable_bit, sw_lap_key_enable_bit,
                                   sw_1hz_enable_bit, sw_10hz_enable_bit,
                                   ctimer_1hz_enable_bit, ctimer_2hz_enable_bit,
                                   ctimer_third_enable_bit, ctimer_32hz_enable_bit,
                                   key_group1_enable_bit};

  // Gated request per source
  wire [`IMR_NSRC-1:0] req_d = factor_flag & mask_vec;

  // Rising request sets a sticky status bit
  wire [`IMR_NSRC-1:0] rise     = req_d & ~req_q;
  wire [`IMR_NSRC-1:0] w1c      = (wr_en & hit_stat) ? pwdata[`IMR_NSRC-1:0] : `IMR_RST_VEC;
  wire [`IMR_NSRC-1:0] stat_d   = rise | (stat_q & ~w1c);
  wire                 irq_d    = |(stat_d & smask_q);

  // Read mux; unused bits read zero
  wire [31:0] rd_word =
      hit_key   ? nib({3'h0, key1_q}) :
      hit_ct    ? nib(ctimer_q) :
      hit_sw    ? nib(sw_q) :
      hit_rf    ? nib({2'h0, rf_q}) :
      hit_stat  ? {21'h000000, stat_q} :
      hit_smask ? {21'h000000, smask_q} :
                  32'h00000000;

  // Handshake next state
  always_comb begin
    case (st_q)
      imr_pkg::IMR_IDLE: st_d = (psel & ~penable) ? imr_pkg::IMR_WAIT : imr_pkg::IMR_IDLE;
      imr_pkg::IMR_WAIT: st_d = (psel & penable) ? imr_pkg::IMR_RESP : imr_pkg::IMR_WAIT;
      imr_pkg::IMR_RESP: st_d = imr_pkg::IMR_IDLE;
      default:           st_d = imr_pkg::IMR_IDLE;
    endcase
  end

  // Bus response flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q      <= imr_pkg::IMR_IDLE;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      st_q      <= st_d;
      pready_q  <= start_acc & psel & penable;
      pslverr_q <= start_acc & psel & penable & ~mapped;
      prdata_q  <= (start_acc & psel & penable & ~pwrite) ? rd_word : 32'h00000000;
    end
  end

  // Key group one mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key1_q <= 1'b0;
    end else if (wr_en & hit_key) begin
      key1_q <= pwdata[0];
    end
  end

  // Clock timer masks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctimer_q <= `IMR_RST_MASK4;
    end else if (wr_en & hit_ct) begin
      ctimer_q <= pwdata[3:0];
    end
  end

  // Stopwatch masks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_q <= `IMR_RST_MASK4;
    end else if (wr_en & hit_sw) begin
      sw_q <= pwdata[3:0];
    end
  end

  // Converter masks; upper bits not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_q <= 2'h0;
    end else if (wr_en & hit_rf) begin
      rf_q <= pwdata[1:0];
    end
  end

  // Status mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smask_q <= `IMR_RST_VEC;
    end else if (wr_en & hit_smask) begin
      smask_q <= pwdata[`IMR_NSRC-1:0];
    end
  end

  // Requests, sticky status and interrupt line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q  <= `IMR_RST_VEC;
      stat_q <= `IMR_RST_VEC;
      irq_q  <= 1'b0;
    end else begin
      req_q  <= req_d;
      stat_q <= stat_d;
      irq_q  <= irq_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq_req = req_q;
  assign irq     = irq_q;

  // Checks
  sequence s_wr(int idx);
    psel && penable && pready && pwrite && mapped && (paddr[ADDR_W-1:2] == idx);
  endsequence

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_access;
    psel && penable;
  endsequence

  chk_key_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_wr(`IMR_IDX_KEY) |=> (key1_q == $past(pwdata[0])))
    else $error("key group mask not written");

  chk_ct1hz_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (factor_flag[`IMR_SRC_CT1] && ctimer_q[3]) |=> irq_req[`IMR_SRC_CT1])
    else $error("clock timer 1 Hz request missing");

  chk_ct2hz_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !ctimer_q[2] |=> !irq_req[`IMR_SRC_CT2])
    else $error("masked 2 Hz request raised");

  chk_ct3rd_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_wr(`IMR_IDX_CTIMER) |=> (ctimer_q[1] == $past(pwdata[1])))
    else $error("third timer mask not written");

  chk_ct32_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (factor_flag[`IMR_SRC_CT32] && ctimer_q[0]) |=> irq_req[`IMR_SRC_CT32])
    else $error("32 Hz request missing");

  chk_run_gate: assert property (@(posedge pclk) disable iff (!presetn)
    irq_req[`IMR_SRC_RUN] |-> $past(sw_q[3] && factor_flag[`IMR_SRC_RUN]))
    else $error("run key request without cause");

  chk_lap_gate: assert property (@(posedge pclk) disable iff (!presetn)
    irq_req[`IMR_SRC_LAP] |-> $past(sw_q[2] && factor_flag[`IMR_SRC_LAP]))
    else $error("lap key request without cause");

  chk_sw_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_wr(`IMR_IDX_SW) |=> (sw_q[1:0] == $past(pwdata[1:0])))
    else $error("stopwatch masks not written");

  chk_sw10_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (factor_flag[`IMR_SRC_SW10] && sw_q[0]) |=> irq_req[`IMR_SRC_SW10])
    else $error("10 Hz request missing");

  chk_rfb_gate: assert property (@(posedge pclk) disable iff (!presetn)
    irq_req[`IMR_SRC_RFB] |-> $past(rf_q[1] && factor_flag[`IMR_SRC_RFB]))
    else $error("reference done request without cause");

  chk_rfm_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !rf_q[0] |=> !irq_req[`IMR_SRC_RFM])
    else $error("masked sensor request raised");

  chk_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && (st_q == imr_pkg::IMR_RESP) && $past(hit_rf && !pwrite)) |-> (prdata[31:2] == 30'h0))
    else $error("unused bits read nonzero");

  chk_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (s_setup ##1 (psel && penable)) |-> (!pready ##1 pready))
    else $error("answer not one wait state");

  chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    (|(stat_q & smask_q) && !wr_en) |=> irq)
    else $error("interrupt line low with pending bit");

  chk_key_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (factor_flag[`IMR_SRC_KEY1] && key1_q) |=> irq_req[`IMR_SRC_KEY1])
    else $error("key group request missing");

  chk_key_masked: assert property (@(posedge pclk) disable iff (!presetn)
    !key1_q |=> !irq_req[`IMR_SRC_KEY1])
    else $error("masked key group request raised");

  chk_ct1hz_masked: assert property (@(posedge pclk) disable iff (!presetn)
    !ctimer_q[3] |=> !irq_req[`IMR_SRC_CT1])
    else $error("masked 1 Hz request raised");

  chk_ct2hz_pass: assert property (@(posedge pclk) disable iff (!presetn)
    (factor_flag[`IMR_SRC_CT2] && ctimer_q[2]) |=> irq_req[`IMR_SRC_CT2])
    else $error("clock timer 2 Hz request missing");

  chk_ct3rd_gate: assert property (@(posedge pclk) disable iff (!presetn)
    irq_req[`IMR_SRC_CT3RD] |-> $past(ctimer_q[1] && factor_flag[`IMR_SRC_CT3RD]))
    else $error("third timer request without cause");

  chk_ct32_masked: assert property (@(posedge pclk) disable iff (!presetn)
    !ctimer_q[0] |=> !irq_req[`IMR_SRC_CT32])
    else $error("masked 32 Hz request raised");

  chk_run_pass: assert property (@(posedge pclk) disable iff (!presetn)
    (factor_flag[`IMR_SRC_RUN] && sw_q[3]) |=> irq_req[`IMR_SRC_RUN])
    else $error("run key request missing");

  chk_lap_pass: assert property (@(posedge pclk) disable iff (!presetn)
    (factor_flag[`IMR_SRC_LAP] && sw_q[2]) |=> irq_req[`IMR_SRC_LAP])
    else $error("lap key request missing");

  chk_sw1hz_gate: assert property (@(posedge pclk) disable iff (!presetn)
    irq_req[`IMR_SRC_SW1] |-> $past(sw_q[1] && factor_flag[`IMR_SRC_SW1]))
    else $error("stopwatch 1 Hz request without cause");

  chk_sw10_masked: assert property (@(posedge pclk) disable iff (!presetn)
    !sw_q[0] |=> !irq_req[`IMR_SRC_SW10])
    else $error("masked 10 Hz request raised");

  chk_rf_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_wr(`IMR_IDX_RF) |=> (rf_q == $past(pwdata[1:0])))
    else $error("converter masks not written");

  chk_status_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_en && hit_stat) |=> ((stat_q & $past(stat_q)) == $past(stat_q)))
    else $error("status bit lost without clear");

  chk_apb_once: assert property (@(posedge pclk) disable iff (!presetn)
    (s_setup ##1 s_access ##1 (s_access && pready)) |=> !pready)
    else $error("answer stands more than one cycle");

endmodule

// ==== dv/tb_imr_top.sv ====
`include "imr_defs.svh"

module tb_imr_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd, d, seed;
  logic [10:0] factor_flag, irq_req, f, sm;
  logic [3:0]  mk [4];
  int          n_errors, checks_done;

  // Mask register indices and their implemented bits
  localparam logic [15:0] IDX [4] = '{`IMR_IDX_KEY, `IMR_IDX_CTIMER, `IMR_IDX_SW, `IMR_IDX_RF};
  localparam logic [3:0]  IMPL [4] = '{4'h1, 4'hf, 4'hf, 4'h3};

  imr_top #(.ADDR_W(18)) u_imr_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .factor_flag(factor_flag), .irq_req(irq_req), .irq(irq)
  );

  // Repeatable random source
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected gate vector in source order
  function automatic logic [10:0] mvec();
    return {mk[3][1:0], mk[2], mk[1], mk[0][0]};
  endfunction

  task automatic tally_and_finish();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    int k;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      n_errors++;
      $display("[FAIL] pready expected 1 seen timeout");
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial begin
    seed = 32'd1503;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    factor_flag = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values of the masks
    for (int r = 0; r < 4; r++) begin
      apb(1'b0, IDX[r], 32'h0);
      chk("mask reset", 32'h0, rd);
    end
    // Write and read back, all ones first, then random
    for (int i = 0; i < 6; i++) begin
      for (int r = 0; r < 4; r++) begin
        d = (i == 0) ? 32'hffffffff : xs();
        apb(1'b1, IDX[r], d);
        mk[r] = d[3:0] & IMPL[r];
        apb(1'b0, IDX[r], 32'h0);
        chk("mask readback", {28'h0, mk[r]}, rd);
        chk("mask slverr", 32'h0, {31'h0, err});
      end
    end
    // Unmapped place refuses both directions
    apb(1'b1, 16'h0000, 32'hffffffff);
    chk("unmapped wr err", 32'h1, {31'h0, err});
    apb(1'b0, 16'h0000, 32'h0);
    chk("unmapped rd data", 32'h0, rd);
    chk("unmapped rd err", 32'h1, {31'h0, err});
    // Gating of requests, sticky status and the interrupt line
    for (int i = 0; i < 10; i++) begin
      factor_flag <= '0;
      for (int r = 0; r < 4; r++) begin
        d = (i == 0) ? 32'hffffffff : xs();
        apb(1'b1, IDX[r], d);
        mk[r] = d[3:0] & IMPL[r];
      end
      d = xs();
      sm = (i == 1) ? 11'h000 : d[10:0];
      apb(1'b1, `IMR_IDX_SMASK, {21'h0, sm});
      apb(1'b1, `IMR_IDX_STATUS, 32'h7ff);
      d = xs();
      f = (i == 0) ? 11'h7ff : d[10:0];
      factor_flag <= f;
      repeat (3) @(posedge pclk);
      #1;
      chk("irq_req", {21'h0, f & mvec()}, {21'h0, irq_req});
      chk("irq set", {31'h0, |(f & mvec() & sm)}, {31'h0, irq});
      @(posedge pclk);
      apb(1'b0, `IMR_IDX_STATUS, 32'h0);
      chk("status", {21'h0, f & mvec()}, rd);
      factor_flag <= '0;
      apb(1'b1, `IMR_IDX_STATUS, 32'h7ff);
      apb(1'b0, `IMR_IDX_STATUS, 32'h0);
      chk("status cleared", 32'h0, rd);
      #1;
      chk("irq cleared", 32'h0, {31'h0, irq});
      chk("irq_req idle", 32'h0, {21'h0, irq_req});
      @(posedge pclk);
    end
    // Reset in mid-run brings every mask back to zero
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, IDX[r], 32'hffffffff);
    end
    factor_flag <= 11'h7ff;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int r = 0; r < 4; r++) begin
      apb(1'b0, IDX[r], 32'h0);
      chk("mask after reset", 32'h0, rd);
    end
    #1;
    chk("irq_req after reset", 32'h0, {21'h0, irq_req});
    chk("irq after reset", 32'h0, {31'h0, irq});
    tally_and_finish();
  end
endmodule
